// ### logic/plcf_regs_map.vh
// Purpose: register map, field positions, reset values and frame layout of the
//          front-end control and status register group.
// Assumes: the host reaches every register over the four-wire serial port.
// Notes:   included by its bare name; definitions only.
//
// Function
// - bit 0 of the first control register at 0x04 turns transmit calibration on at 1, is read/write and resets to 0.
// - bit 1 of the first control register turns receive calibration on at 1, is read/write and resets to 0.
// - bit 3 of the first control register picks the filter response, 0 for band A and 1 for bands B, C and D.
// - bit 6 of the first control register is read-only and shows 1 while the transmit path is ready.
// - bit 7 of the first control register is read-only and shows 1 while the receive path is ready.
// - bit 5 of the second control register at 0x05 turns on reporting of the thermal overload flag.
// - bit 6 of the second control register turns on reporting of the current overload flag.
// - writing 101 to bits 4..2 of the reset register at 0x09 returns the enable, second and third control and gain registers to default.
// - the three soft-reset code bits at positions 2, 3 and 4 are write-only and default to zero.
// - bit 5 of the reset register latches on a thermal overload, holds until a written 0 clears it, and reads 0 otherwise.
// - bit 6 of the reset register latches on a current overload, holds until a written 0 clears it, and reads 0 otherwise.
// - the register at 0x0A returns a fixed eight-bit die identifier on every read and is read-only.
// - every one of these registers is programmed and read only through the serial peripheral port.
`ifndef PLCF_REGS_MAP_VH
`define PLCF_REGS_MAP_VH

// register addresses, seven bits wide
`define PLCF_ADDR_W 7
`define PLCF_ADDR_CAL_BAND_READY 7'h04
`define PLCF_ADDR_OVL_FLAG_EN 7'h05
`define PLCF_ADDR_SRST_OVL_FLAGS 7'h09
`define PLCF_ADDR_DIE_IDENTIFIER_BITS 7'h0A

// data width
`define PLCF_DATA_W 8

// first control register fields
`define PLCF_TX_CAL_BIT 0
`define PLCF_RX_CAL_BIT 1
`define PLCF_BAND_SEL_BIT 3
`define PLCF_TX_READY_BIT 6
`define PLCF_RX_READY_BIT 7
`define PLCF_CAL_BAND_RESET 8'h00

// second control register fields
`define PLCF_THERM_EN_BIT 5
`define PLCF_CURR_EN_BIT 6
`define PLCF_OVL_FLAG_EN_RESET 8'h01

// reset register fields
`define PLCF_SRST_LSB 2
`define PLCF_SRST_MSB 4
`define PLCF_SRST_CODE 3'h5
`define PLCF_THERM_FLAG_BIT 5
`define PLCF_CURR_FLAG_BIT 6
`define PLCF_NUM_FLAGS 2

// serial frame: one command byte then one data byte, msb first
`define PLCF_CNT_W 5
`define PLCF_CNT_ZERO 5'h00
`define PLCF_CNT_ONE 5'h01
`define PLCF_CMD_LAST 5'h07
`define PLCF_CMD_DONE 5'h08
`define PLCF_FRAME_LAST 5'h0F
`define PLCF_FRAME_DONE 5'h10
`define PLCF_RW_BIT 7

`endif

// ### logic/plcf_reset_sync.v
// Purpose: release of the active-low reset through two flip-flops.
// Assumes: rst_n may assert at any time; release is taken on core_clk.
// Notes:   assertion is immediate, release is delayed by two edges.
`timescale 1ns/1ps

module plcf_reset_sync (
    input wire core_clk,
    input wire rst_n,
    output wire rst_sync_n
);

// ==========================================================================
// two-stage release
reg stage1_q;
reg stage2_q;

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        stage1_q <= 1'b0;
        stage2_q <= 1'b0;
    end else begin
        stage1_q <= 1'b1;
        stage2_q <= stage1_q;
    end
end

assign rst_sync_n = stage2_q;

endmodule

// ### logic/plcf_sticky_flag.v
// Purpose: one latched overload flag with its reporting enable and write-zero clear.
// Assumes: event is a level synchronous to core_clk.
// Notes:   a set in the same cycle as a clear wins.
`timescale 1ns/1ps

module plcf_sticky_flag (
    input wire core_clk,
    input wire rst_sync_n,
    input wire event_in,
    input wire report_en,
    input wire clear,
    output wire flag
);

// ==========================================================================
// latch
reg flag_q;
reg flag_d;

always @* begin
    flag_d = flag_q;
    if (clear) begin
        flag_d = 1'b0;
    end
    if (event_in && report_en) begin
        flag_d = 1'b1;
    end
end

always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        flag_q <= 1'b0;
    end else begin
        flag_q <= flag_d;
    end
end

assign flag = flag_q;

endmodule

// ### logic/plcf_regs.v
// Purpose: control, status, soft-reset and die-identifier registers of the
//          front-end, reached over a four-wire serial port.
// Assumes: serial pins are synchronous to core_clk and sclk is well below
//          half the core rate; mode 0, msb first, 16-bit frames.
// Notes:   soft reset of registers kept outside this group leaves as a pulse.
`timescale 1ns/1ps
`include "plcf_regs_map.vh"

module plcf_regs #(
    parameter [7:0] DIE_IDENTIFIER_BITS_VALUE = 8'h5A // arbitrary neutral value
) (
    input wire core_clk,
    input wire rst_n,
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_mosi,
    output wire spi_miso,
    output wire spi_miso_oe,
    input wire tx_ready,
    input wire rx_ready,
    input wire pa_thermal_overload,
    input wire pa_current_overload,
    output wire tx_cal_en,
    output wire rx_cal_en,
    output wire filter_band_select,
    output wire thermal_flag_en,
    output wire current_flag_en,
    output wire thermal_flag,
    output wire current_flag,
    output wire soft_reset_pulse
);

// ==========================================================================
// address decode helpers
function addr_hit;
    input [`PLCF_ADDR_W-1:0] addr;
    input [`PLCF_ADDR_W-1:0] target;
    begin
        addr_hit = (addr == target);
    end
endfunction

function soft_reset_code_ok;
    input [`PLCF_DATA_W-1:0] data;
    begin
        soft_reset_code_ok = (data[`PLCF_SRST_MSB:`PLCF_SRST_LSB] == `PLCF_SRST_CODE);
    end
endfunction

// ==========================================================================
// reset release
wire rst_sync_n;

plcf_reset_sync u_reset_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .rst_sync_n(rst_sync_n)
);

// ==========================================================================
// serial edge detection
reg sclk_q;
wire sclk_rise;
wire sclk_fall;
wire frame_on;

assign frame_on = ~spi_cs_n;
assign sclk_rise = spi_sclk & ~sclk_q;
assign sclk_fall = ~spi_sclk & sclk_q;

always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        sclk_q <= 1'b0;
    end else begin
        sclk_q <= spi_sclk;
    end
end

// ==========================================================================
// register state
reg tx_cal_q;
reg rx_cal_q;
reg band_sel_q;
reg therm_en_q;
reg curr_en_q;
reg soft_reset_pulse_q;
wire [`PLCF_NUM_FLAGS-1:0] flag_vec;

// ==========================================================================
// frame engine
reg [`PLCF_CNT_W-1:0] bit_cnt_q;
reg [`PLCF_DATA_W-1:0] shift_in_q;
reg [`PLCF_DATA_W-1:0] cmd_q;
reg [`PLCF_DATA_W-1:0] rd_shift_q;
reg miso_q;
reg miso_oe_q;
reg wr_commit;
reg rd_load;
wire [`PLCF_DATA_W-1:0] cmd_now;
wire [`PLCF_DATA_W-1:0] data_now;
wire [`PLCF_ADDR_W-1:0] wr_addr;

assign cmd_now = {shift_in_q[`PLCF_DATA_W-2:0], spi_mosi};
assign data_now = {shift_in_q[`PLCF_DATA_W-2:0], spi_mosi};
assign wr_addr = cmd_q[`PLCF_ADDR_W-1:0];

always @* begin
    rd_load = frame_on && sclk_rise && (bit_cnt_q == `PLCF_CMD_LAST)
        && cmd_now[`PLCF_RW_BIT];
    wr_commit = frame_on && sclk_rise && (bit_cnt_q == `PLCF_FRAME_LAST)
        && !cmd_q[`PLCF_RW_BIT];
end

// read data path; live status sampled at the end of the command byte
reg [`PLCF_DATA_W-1:0] rd_data;

always @* begin
    rd_data = {`PLCF_DATA_W{1'b0}};
    if (addr_hit(cmd_now[`PLCF_ADDR_W-1:0], `PLCF_ADDR_CAL_BAND_READY)) begin
        rd_data[`PLCF_TX_CAL_BIT] = tx_cal_q;
        rd_data[`PLCF_RX_CAL_BIT] = rx_cal_q;
        rd_data[`PLCF_BAND_SEL_BIT] = band_sel_q;
        rd_data[`PLCF_TX_READY_BIT] = tx_ready;
        rd_data[`PLCF_RX_READY_BIT] = rx_ready;
    end else if (addr_hit(cmd_now[`PLCF_ADDR_W-1:0], `PLCF_ADDR_OVL_FLAG_EN)) begin
        rd_data = `PLCF_OVL_FLAG_EN_RESET & ~(8'h01 << `PLCF_THERM_EN_BIT)
            & ~(8'h01 << `PLCF_CURR_EN_BIT);
        rd_data[`PLCF_THERM_EN_BIT] = therm_en_q;
        rd_data[`PLCF_CURR_EN_BIT] = curr_en_q;
    end else if (addr_hit(cmd_now[`PLCF_ADDR_W-1:0], `PLCF_ADDR_SRST_OVL_FLAGS)) begin
        // code bits always read zero
        rd_data[`PLCF_THERM_FLAG_BIT] = flag_vec[0];
        rd_data[`PLCF_CURR_FLAG_BIT] = flag_vec[1];
    end else if (addr_hit(cmd_now[`PLCF_ADDR_W-1:0], `PLCF_ADDR_DIE_IDENTIFIER_BITS)) begin
        rd_data = DIE_IDENTIFIER_BITS_VALUE;
    end
end

always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        bit_cnt_q <= `PLCF_CNT_ZERO;
        shift_in_q <= {`PLCF_DATA_W{1'b0}};
        cmd_q <= {`PLCF_DATA_W{1'b0}};
        rd_shift_q <= {`PLCF_DATA_W{1'b0}};
        miso_q <= 1'b0;
        miso_oe_q <= 1'b0;
    end else begin
        miso_oe_q <= frame_on;
        if (!frame_on) begin
            // a frame cut short by cs_n leaves no effect
            bit_cnt_q <= `PLCF_CNT_ZERO;
            rd_shift_q <= {`PLCF_DATA_W{1'b0}};
            miso_q <= 1'b0;
        end else begin
            if (sclk_rise && (bit_cnt_q != `PLCF_FRAME_DONE)) begin
                shift_in_q <= data_now;
                bit_cnt_q <= bit_cnt_q + `PLCF_CNT_ONE;
                if (bit_cnt_q == `PLCF_CMD_LAST) begin
                    cmd_q <= cmd_now;
                    rd_shift_q <= rd_load ? rd_data : {`PLCF_DATA_W{1'b0}};
                end
            end
            if (sclk_fall && (bit_cnt_q >= `PLCF_CMD_DONE)
                    && (bit_cnt_q != `PLCF_FRAME_DONE)) begin
                miso_q <= rd_shift_q[`PLCF_DATA_W-1];
                rd_shift_q <= {rd_shift_q[`PLCF_DATA_W-2:0], 1'b0};
            end
        end
    end
end

// ==========================================================================
// write decode
wire wr_cal_band;
wire wr_flag_en;
wire wr_srst;
wire srst_hit;

assign wr_cal_band = wr_commit && addr_hit(wr_addr, `PLCF_ADDR_CAL_BAND_READY);
assign wr_flag_en = wr_commit && addr_hit(wr_addr, `PLCF_ADDR_OVL_FLAG_EN);
assign wr_srst = wr_commit && addr_hit(wr_addr, `PLCF_ADDR_SRST_OVL_FLAGS);
assign srst_hit = wr_srst && soft_reset_code_ok(data_now);

// ==========================================================================
// first control register
localparam [`PLCF_DATA_W-1:0] CAL_BAND_RST = `PLCF_CAL_BAND_RESET;

always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        tx_cal_q <= CAL_BAND_RST[`PLCF_TX_CAL_BIT];
        rx_cal_q <= CAL_BAND_RST[`PLCF_RX_CAL_BIT];
        band_sel_q <= CAL_BAND_RST[`PLCF_BAND_SEL_BIT];
    end else if (wr_cal_band) begin
        // ready bits and reserved bits are not stored
        tx_cal_q <= data_now[`PLCF_TX_CAL_BIT];
        rx_cal_q <= data_now[`PLCF_RX_CAL_BIT];
        band_sel_q <= data_now[`PLCF_BAND_SEL_BIT];
    end
end

// ==========================================================================
// second control register
// soft-reset value of the second control register
wire [`PLCF_DATA_W-1:0] flag_en_rst;

assign flag_en_rst = `PLCF_OVL_FLAG_EN_RESET;

always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        therm_en_q <= 1'b0;
        curr_en_q <= 1'b0;
    end else if (srst_hit) begin
        therm_en_q <= flag_en_rst[`PLCF_THERM_EN_BIT];
        curr_en_q <= flag_en_rst[`PLCF_CURR_EN_BIT];
    end else if (wr_flag_en) begin
        therm_en_q <= data_now[`PLCF_THERM_EN_BIT];
        curr_en_q <= data_now[`PLCF_CURR_EN_BIT];
    end
end

// ==========================================================================
// reset register: soft-reset pulse and latched overload flags
always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        soft_reset_pulse_q <= 1'b0;
    end else begin
        soft_reset_pulse_q <= srst_hit;
    end
end

wire [`PLCF_NUM_FLAGS-1:0] flag_event;
wire [`PLCF_NUM_FLAGS-1:0] flag_report_en;
wire [`PLCF_NUM_FLAGS-1:0] flag_clear;

assign flag_event = {pa_current_overload, pa_thermal_overload};
assign flag_report_en = {curr_en_q, therm_en_q};
assign flag_clear = {wr_srst && !data_now[`PLCF_CURR_FLAG_BIT],
                     wr_srst && !data_now[`PLCF_THERM_FLAG_BIT]};

genvar gi;
generate
    for (gi = 0; gi < `PLCF_NUM_FLAGS; gi = gi + 1) begin : g_flag
        plcf_sticky_flag u_flag (
            .core_clk(core_clk),
            .rst_sync_n(rst_sync_n),
            .event_in(flag_event[gi]),
            .report_en(flag_report_en[gi]),
            .clear(flag_clear[gi]),
            .flag(flag_vec[gi])
        );
    end
endgenerate

// ==========================================================================
// outputs
assign spi_miso = miso_q;
assign spi_miso_oe = miso_oe_q;
assign tx_cal_en = tx_cal_q;
assign rx_cal_en = rx_cal_q;
assign filter_band_select = band_sel_q;
assign thermal_flag_en = therm_en_q;
assign current_flag_en = curr_en_q;
assign thermal_flag = flag_vec[0];
assign current_flag = flag_vec[1];
assign soft_reset_pulse = soft_reset_pulse_q;

endmodule

// ### verif/plcf_host_model.sv
// Purpose: host side of the serial port, sends the first nbits bits of one 16-bit frame per call
// Assumes: mode 0, msb first, pins change at core_clk falling edge
// Notes: mosi shows the inverse of its last bit while released
`timescale 1ns/1ps

module plcf_host_model (
    input wire core_clk,
    input wire spi_miso,
    output reg spi_sclk,
    output reg spi_cs_n,
    output reg spi_mosi
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // nbits below 16 aborts the frame early
    task xfer(input [15:0] frame, input integer nbits, output [7:0] rd);
        integer i;
        begin
            rd = 8'h00;
            @(negedge core_clk);
            spi_cs_n = 1'b0;
            for (i = 15; i > 15 - nbits; i = i - 1) begin
                spi_mosi = frame[i];
                repeat (3) @(negedge core_clk);
                rd = {rd[6:0], spi_miso};
                spi_sclk = 1'b1;
                repeat (2) @(negedge core_clk);
                spi_sclk = 1'b0;
            end
            repeat (3) @(negedge core_clk);
            spi_cs_n = 1'b1;
            spi_mosi = ~spi_mosi;
            repeat (3) @(negedge core_clk);
        end
    endtask
endmodule

// ### verif/plcf_regs_props.sv
// Purpose: port-level checks of the register group
// Assumes: frames are separated by select high
// Notes: bound to plcf_regs below
`timescale 1ns/1ps

module plcf_regs_props (
    input wire core_clk,
    input wire rst_n,
    input wire spi_cs_n,
    input wire spi_miso,
    input wire spi_miso_oe,
    input wire pa_thermal_overload,
    input wire pa_current_overload,
    input wire tx_cal_en,
    input wire rx_cal_en,
    input wire filter_band_select,
    input wire thermal_flag_en,
    input wire current_flag_en,
    input wire thermal_flag,
    input wire current_flag,
    input wire soft_reset_pulse
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire [4:0] cfg = {tx_cal_en, rx_cal_en, filter_band_select, thermal_flag_en, current_flag_en};

    chk_oe_follows_cs: assert property (spi_miso_oe == $past(!spi_cs_n))
        else $error("miso enable does not follow select");
    chk_miso_idle: assert property (spi_cs_n && $past(spi_cs_n) |-> !spi_miso)
        else $error("miso driven outside a frame");
    chk_pulse_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
        else $error("soft reset pulse longer than one cycle");
    chk_srst_clears_en: assert property (soft_reset_pulse |-> !thermal_flag_en && !current_flag_en)
        else $error("enables not defaulted by soft reset");
    chk_therm_latch: assert property (pa_thermal_overload && thermal_flag_en |=> thermal_flag)
        else $error("thermal flag not latched");
    chk_curr_latch: assert property (pa_current_overload && current_flag_en |=> current_flag)
        else $error("current flag not latched");
    chk_flags_hold: assert property (spi_cs_n && $past(spi_cs_n, 4) |=>
        thermal_flag >= $past(thermal_flag) && current_flag >= $past(current_flag))
        else $error("flag dropped without a write");
    chk_therm_gated: assert property (!thermal_flag && !thermal_flag_en |=> !thermal_flag)
        else $error("thermal flag set while disabled");
    chk_curr_gated: assert property (!current_flag && !current_flag_en |=> !current_flag)
        else $error("current flag set while disabled");
    chk_cfg_idle: assert property (spi_cs_n && $past(spi_cs_n, 4) |=> $stable(cfg))
        else $error("configuration changed outside a frame");
endmodule

bind plcf_regs plcf_regs_props i_props (
    .core_clk(core_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .pa_thermal_overload(pa_thermal_overload),
    .pa_current_overload(pa_current_overload), .tx_cal_en(tx_cal_en), .rx_cal_en(rx_cal_en),
    .filter_band_select(filter_band_select), .thermal_flag_en(thermal_flag_en),
    .current_flag_en(current_flag_en), .thermal_flag(thermal_flag),
    .current_flag(current_flag), .soft_reset_pulse(soft_reset_pulse));

// ### verif/plcf_tb.sv
// Purpose: self-checking bench of the register group
// Assumes: inputs change at the falling edge of core_clk
// Notes: die identifier parameter set to an arbitrary value
`timescale 1ns/1ps
`include "plcf_regs_map.vh"

module testbench;
    localparam [7:0] DIE = 8'hC3; // arbitrary
    reg core_clk, rst_n, tx_ready, rx_ready, pa_thermal_overload, pa_current_overload;
    wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, tx_cal_en, rx_cal_en;
    wire filter_band_select, thermal_flag_en, current_flag_en, thermal_flag, current_flag;
    wire soft_reset_pulse;
    wire [7:0] cfg = {3'h0, current_flag_en, thermal_flag_en, filter_band_select, rx_cal_en,
        tx_cal_en};
    wire [7:0] flags = {6'h00, current_flag, thermal_flag};
    integer n_errors, comparisons, cycles;
    reg [7:0] n_pulses, x;

    plcf_regs #(.DIE_IDENTIFIER_BITS_VALUE(DIE)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .tx_ready(tx_ready), .rx_ready(rx_ready),
        .pa_thermal_overload(pa_thermal_overload), .pa_current_overload(pa_current_overload),
        .tx_cal_en(tx_cal_en), .rx_cal_en(rx_cal_en), .filter_band_select(filter_band_select),
        .thermal_flag_en(thermal_flag_en), .current_flag_en(current_flag_en),
        .thermal_flag(thermal_flag), .current_flag(current_flag),
        .soft_reset_pulse(soft_reset_pulse));
    plcf_host_model i_host (.core_clk(core_clk), .spi_miso(spi_miso), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        cycles = cycles + 1;
        if (soft_reset_pulse === 1'b1)
            n_pulses = n_pulses + 8'h01;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            give_verdict;
        end
    end

    // ==========
    // tasks
    task give_verdict;
        begin
            if (n_errors == 0 && comparisons > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task check(input [7:0] got, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("BAD %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [6:0] a, input [7:0] d);
        i_host.xfer({1'b0, a, d}, 16, x);
    endtask
    task rd_chk(input [6:0] a, input [7:0] exp);
        begin
            i_host.xfer({1'b1, a, 8'h00}, 16, x);
            check(x, exp);
        end
    endtask
    task hit(input cur);
        begin
            pa_current_overload = cur;
            pa_thermal_overload = ~cur;
            @(negedge core_clk);
            pa_current_overload = 1'b0;
            pa_thermal_overload = 1'b0;
            repeat (2) @(negedge core_clk);
        end
    endtask
    task t_defaults;
        begin
            check(cfg, 8'h00);
            rd_chk(`PLCF_ADDR_CAL_BAND_READY, 8'h00);
            rd_chk(`PLCF_ADDR_OVL_FLAG_EN, 8'h01);
            rd_chk(`PLCF_ADDR_SRST_OVL_FLAGS, 8'h00);
            rd_chk(`PLCF_ADDR_DIE_IDENTIFIER_BITS, DIE);
        end
    endtask
    task t_ctrl1;
        begin
            wr(`PLCF_ADDR_CAL_BAND_READY, 8'hFF);
            check(cfg, 8'h07);
            rd_chk(`PLCF_ADDR_CAL_BAND_READY, 8'h0B);
            tx_ready = 1'b1;
            rd_chk(`PLCF_ADDR_CAL_BAND_READY, 8'h4B);
            tx_ready = 1'b0;
            rx_ready = 1'b1;
            rd_chk(`PLCF_ADDR_CAL_BAND_READY, 8'h8B);
            rx_ready = 1'b0;
            wr(`PLCF_ADDR_CAL_BAND_READY, 8'h08);
            check(cfg, 8'h04);
            wr(`PLCF_ADDR_DIE_IDENTIFIER_BITS, 8'hFF);
            rd_chk(`PLCF_ADDR_DIE_IDENTIFIER_BITS, DIE);
            wr(7'h07, 8'hFF);
            rd_chk(7'h07, 8'h00);
            i_host.xfer({1'b0, `PLCF_ADDR_CAL_BAND_READY, 8'h03}, 10, x);
            check(cfg, 8'h04);
        end
    endtask
    task t_flags;
        begin
            hit(1'b0);
            hit(1'b1);
            check(flags, 8'h00);
            wr(`PLCF_ADDR_OVL_FLAG_EN, 8'h60);
            rd_chk(`PLCF_ADDR_OVL_FLAG_EN, 8'h61);
            hit(1'b0);
            rd_chk(`PLCF_ADDR_SRST_OVL_FLAGS, 8'h20);
            hit(1'b1);
            rd_chk(`PLCF_ADDR_SRST_OVL_FLAGS, 8'h60);
            wr(`PLCF_ADDR_SRST_OVL_FLAGS, 8'h40);
            rd_chk(`PLCF_ADDR_SRST_OVL_FLAGS, 8'h40);
            wr(`PLCF_ADDR_SRST_OVL_FLAGS, 8'h00);
            check(flags, 8'h00);
        end
    endtask
    task t_soft;
        begin
            hit(1'b0);
            wr(`PLCF_ADDR_CAL_BAND_READY, 8'h09);
            wr(`PLCF_ADDR_SRST_OVL_FLAGS, 8'h6C);
            check(n_pulses, 8'h00);
            check(cfg, 8'h1D);
            wr(`PLCF_ADDR_SRST_OVL_FLAGS, 8'h74);
            check(n_pulses, 8'h01);
            check(cfg, 8'h05);
            rd_chk(`PLCF_ADDR_OVL_FLAG_EN, 8'h01);
            rd_chk(`PLCF_ADDR_SRST_OVL_FLAGS, 8'h20);
        end
    endtask

    // ==========
    // main sequence
    initial begin
        n_errors = 0;
        comparisons = 0;
        cycles = 0;
        n_pulses = 8'h00;
        rst_n = 1'b0;
        tx_ready = 1'b0;
        rx_ready = 1'b0;
        pa_thermal_overload = 1'b0;
        pa_current_overload = 1'b0;
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        t_defaults;
        t_ctrl1;
        t_flags;
        t_soft;
        give_verdict;
    end
endmodule
